// file: design/pcstk_top.v
`include "pcstk_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pcstk_top #(
    parameter PC_W = `PCSTK_PC_W,
    parameter DEPTH = `PCSTK_DEPTH
) (
    // clock and reset
    input wire ref_clk_i,
    input wire resetn_i,
    // sequencing from the decoder, one per instruction cycle
    input wire advance_i,
    input wire call_i,
    input wire goto_i,
    input wire [`PCSTK_BR_W-1:0] branch_addr_i,
    input wire irq_vector_i,
    input wire [PC_W-1:0] vector_addr_i,
    input wire return_i,
    // software access to low byte and latch
    input wire low_wr_i,
    input wire [`PCSTK_LOW_W-1:0] low_wdata_i,
    input wire latch_wr_i,
    input wire [`PCSTK_LOW_W-1:0] latch_wdata_i,
    // state
    output reg [PC_W-1:0] pc_o,
    output reg [`PCSTK_LOW_W-1:0] counter_low_byte_o,
    output reg [`PCSTK_LOW_W-1:0] upper_address_latch_o
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg [1:0] rst_sync_r;
    wire rst_n;
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // next counter
    // ----------------------------------------
    wire [PC_W-1:0] stack_top;
    wire push;
    wire pop;
    reg [PC_W-1:0] pc_nxt;

    // ----------------------------------------
    // target helpers
    // ----------------------------------------
    // absolute branch: page bits from the latch, offset from the opcode
    function [PC_W-1:0] branch_target;
        input [`PCSTK_LOW_W-1:0] latch;
        input [`PCSTK_BR_W-1:0] addr;
        begin
            branch_target = {latch[`PCSTK_LATCH_HI_MSB:`PCSTK_LATCH_PG_LSB], addr};
        end
    endfunction

    // whole high part from the latch, so a table offset that runs past
    // a 256-word block wraps inside it rather than carrying upward
    function [PC_W-1:0] low_target;
        input [`PCSTK_LOW_W-1:0] latch;
        input [`PCSTK_LOW_W-1:0] low;
        begin
            low_target = {latch[`PCSTK_HIGH_W-1:0], low};
        end
    endfunction

    // sequential step; the 8K space wraps from its top word to zero
    function [PC_W-1:0] pc_step;
        input [PC_W-1:0] pc;
        begin
            pc_step = pc + {{(PC_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // interrupt vectoring takes priority over the instruction's own flow;
    // a call that loses to a return must not push, or the stack drifts
    assign push = irq_vector_i | (call_i & ~return_i);
    assign pop = return_i & ~irq_vector_i;

    always @* begin
        pc_nxt = pc_o;
        if (irq_vector_i) begin
            pc_nxt = vector_addr_i;
        end else if (return_i) begin
            pc_nxt = stack_top;
        end else if (call_i | goto_i) begin
            // page from latch, offset within 2K page
            pc_nxt = branch_target(upper_address_latch_o, branch_addr_i);
        end else if (low_wr_i) begin
            // computed branch: no carry from low byte, high from latch
            pc_nxt = low_target(upper_address_latch_o, low_wdata_i);
        end else if (advance_i) begin
            pc_nxt = pc_step(pc_o);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pc_o <= `PCSTK_PC_RST;
            counter_low_byte_o <= 8'h00;
        end else begin
            pc_o <= pc_nxt;
            counter_low_byte_o <= pc_nxt[`PCSTK_LOW_W-1:0];
        end
    end

    // latch written only by software, never by stack traffic
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            upper_address_latch_o <= `PCSTK_LATCH_RST;
        end else if (latch_wr_i) begin
            upper_address_latch_o <= latch_wdata_i;
        end
    end

    // stack pointer has no port at all
    pcstk_stack #(
        .WIDTH(PC_W),
        .DEPTH(DEPTH),
        .PTR_W(`PCSTK_PTR_W)
    ) u_stack (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .push_i(push),
        .pop_i(pop),
        .push_data_i(pc_o),
        .top_o(stack_top)
    );
endmodule

`default_nettype wire

// file: design/pcstk_consts.vh
`ifndef PCSTK_CONSTS_VH
`define PCSTK_CONSTS_VH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PCSTK_PC_W 13
`define PCSTK_LOW_W 8
`define PCSTK_HIGH_W 5
`define PCSTK_BR_W 11
`define PCSTK_DEPTH 8
`define PCSTK_PTR_W 3
`define PCSTK_PC_RST 13'h0000
`define PCSTK_LATCH_RST 8'h00
`define PCSTK_PTR_RST 3'h0

// ----------------------------------------
// field positions of the upper-address latch
// ----------------------------------------
`define PCSTK_LATCH_HI_MSB 4
`define PCSTK_LATCH_PG_LSB 3

`endif

// file: design/pcstk_stack.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// circular return-address stack
// ----------------------------------------
module pcstk_stack #(
    parameter WIDTH = 13,
    parameter DEPTH = 8,
    parameter PTR_W = 3
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // operations
    input wire push_i,
    input wire pop_i,
    input wire [WIDTH-1:0] push_data_i,
    // top entry
    output wire [WIDTH-1:0] top_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [PTR_W-1:0] ptr_r;
    wire [PTR_W-1:0] ptr_dec;
    integer k;

    // pointer names the next free slot; top is one below
    assign ptr_dec = ptr_r - {{(PTR_W-1){1'b0}}, 1'b1};
    assign top_o = mem_r[ptr_dec];

    // pointer wraps mod depth, no overflow or underflow flag
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_r <= {PTR_W{1'b0}};
        end else if (push_i) begin
            ptr_r <= ptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
        end else if (pop_i) begin
            ptr_r <= ptr_dec;
        end
    end

    // ninth push lands on the first slot again
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem_r[k] <= {WIDTH{1'b0}};
            end
        end else if (push_i) begin
            mem_r[ptr_r] <= push_data_i;
        end
    end
endmodule

`default_nettype wire

// file: test/pcstk_dec.sv
`timescale 1ns/1ps
`default_nettype none
module pcstk_dec (
    input wire logic [2:0] op_i,
    output logic [4:0] s_o
);
    // at most one strobe a cycle, for op 1 to 5: advance, call, goto, irq, return
    assign s_o = 5'(6'h1 << op_i >> 1);
endmodule
`default_nettype wire

// file: test/pcstk_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pcstk_checker #(parameter PC_W = 13, parameter DEPTH = 8) (
    input wire logic ref_clk_i, resetn_i, advance_i, call_i, goto_i, irq_vector_i,
    input wire logic return_i, low_wr_i, latch_wr_i,
    input wire logic [10:0] branch_addr_i,
    input wire logic [PC_W-1:0] vector_addr_i, pc_o,
    input wire logic [7:0] low_wdata_i, latch_wdata_i, counter_low_byte_o,
    input wire logic [7:0] upper_address_latch_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire hi = irq_vector_i | return_i;
    wire br = call_i | goto_i;
    wire [1:0] pg = upper_address_latch_o[4:3];
    wire [4:0] hl = upper_address_latch_o[4:0];
    wire [7:0] lat = upper_address_latch_o;
    sequence s_call; call_i && !hi; endsequence
    sequence s_ret; return_i && !irq_vector_i; endsequence
    sequence s_br; br && !hi; endsequence
    sequence s_low; low_wr_i && !(hi | br); endsequence
    sequence s_adv; advance_i && !(hi | br | low_wr_i); endsequence
    a_low_mirror: assert property (counter_low_byte_o == pc_o[7:0])
        else $error("low");
    a_branch_load: assert property (s_br |=> pc_o == {$past(pg), $past(branch_addr_i)})
        else $error("branch");
    a_low_write: assert property (s_low |=> pc_o == {$past(hl), $past(low_wdata_i)})
        else $error("low write");
    a_irq_vector: assert property (irq_vector_i |=> pc_o == $past(vector_addr_i))
        else $error("irq");
    a_call_return: assert property (s_call ##1 s_ret |=> pc_o == $past(pc_o, 2))
        else $error("return");
    a_latch_keep: assert property ((br | hi) && !latch_wr_i |=> $stable(lat))
        else $error("latch");
    a_latch_write: assert property (latch_wr_i |=> lat == $past(latch_wdata_i))
        else $error("latch wr");
    a_advance_step: assert property (s_adv |=> pc_o == PC_W'($past(pc_o) + 1))
        else $error("advance");
    a_idle_hold: assert property (!(advance_i | hi | br | low_wr_i) |=> $stable(pc_o))
        else $error("hold");
endmodule
bind pcstk_top pcstk_checker #(.PC_W(PC_W), .DEPTH(DEPTH)) pcstk_checker_i (.*);
`default_nettype wire

// file: test/tb_pcstk_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pcstk_top;
    logic clk = 0, rstn = 0, lw = 0, xw = 0;
    logic [2:0] op = 0;
    logic [10:0] ba = 0;
    logic [12:0] va = 0;
    logic [7:0] ld = 0, xd = 0;
    wire [4:0] s;
    wire [12:0] pc;
    wire [7:0] lo, lat;
    int fails = 0, checks_done = 0;
    pcstk_dec pcstk_dec_i (.op_i(op), .s_o(s));
    pcstk_top pcstk_top_i (.ref_clk_i(clk), .resetn_i(rstn), .advance_i(s[0]), .call_i(s[1]),
        .goto_i(s[2]), .branch_addr_i(ba), .irq_vector_i(s[3]), .vector_addr_i(va),
        .return_i(s[4]), .low_wr_i(lw), .low_wdata_i(ld), .latch_wr_i(xw),
        .latch_wdata_i(xd), .pc_o(pc), .counter_low_byte_o(lo), .upper_address_latch_o(lat));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [12:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task close_out;
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task step(input logic [2:0] o, input logic [10:0] a);
        op = o;
        ba = a;
        @(posedge clk) #1;
    endtask
    task wr_latch(input logic [7:0] d);
        xw = 1;
        xd = d;
        @(posedge clk) #1 xw = 0;
    endtask
    task wr_low(input logic [7:0] d);
        op = 3'h0;
        lw = 1;
        ld = d;
        @(posedge clk) #1 lw = 0;
    endtask
    task do_reset;
        rstn = 0;
        repeat (10) @(posedge clk);
        #1 chk(pc, 0);
        chk({5'h0, lat}, 0);
        chk({5'h0, lo}, 0);
        rstn = 1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task t_paging;
        wr_latch(8'hfa);
        step(3'h3, 11'h7ff); chk(pc, 13'h1fff);
        wr_low(8'hff);
        chk(pc, 13'h1aff);
        chk({5'h0, lo}, 13'h00ff);
        step(3'h1, 0); chk(pc, 13'h1b00);
        step(0, 0);
    endtask
    task t_stack;
        // latch bits 4:3 set on purpose to exercise paging on call
        wr_latch(8'h18);
        for (int i = 1; i < 10; i++) step(3'h2, 11'(i));
        for (int i = 0; i < 9; i++) begin
            step(3'h5, 0);
            chk(pc, i < 8 ? 13'h1808 - 13'(i) : 13'h1808);
        end
        chk({5'h0, lat}, 13'h0018);
        step(0, 0);
    endtask
    task t_irq;
        va = 13'h0004;
        step(3'h4, 0); chk(pc, 13'h0004);
        step(3'h5, 0); chk(pc, 13'h1808);
        step(0, 0);
        wr_latch(8'h00);
        step(3'h3, 11'h123); chk(pc, 13'h0123);
        step(0, 0);
    endtask
    initial begin
        do_reset;
        t_paging;
        t_stack;
        t_irq;
        do_reset;
        close_out;
    end
endmodule
`default_nettype wire
